//--- uart_err_pkg.sv
package uart_err_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_DIVISOR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

  // serial_status_reg: flags occupy bits 6..3
  localparam int STAT_FLAG_LSB = 3;
  localparam int STAT_FLAG_MSB = 6;

  // index into the 4-bit flag vector
  localparam int FL_PAR = 0;
  localparam int FL_FRM = 1;
  localparam int FL_OVR = 2;
  localparam int FL_FULL = 3;

  // serial_mode_reg fields
  localparam int MODE_RX_ENABLE_BIT = 0;
  localparam int MODE_SYNC_BIT = 1;
  localparam int MODE_PARITY_EN_BIT = 2;
  localparam int MODE_ODD_BIT = 3;
  localparam int MODE_TWO_STOP_BIT = 4;
  localparam logic [7:0] MODE_WRITE_MASK = 8'h1f;

  // interrupt status, clear and enable bits
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_FRM_BIT = 2;
  localparam int IRQ_PAR_BIT = 3;

  // values after reset
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // oversampling counts, in baud ticks, and the last data bit index
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_t;

endpackage

//--- baud_tick_gen.sv
`timescale 1ns/1ps
module baud_tick_gen
  import uart_err_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } baud_regs_t;

  localparam baud_regs_t BAUD_RESET = '{cnt: 8'h00, tick: 1'b0};

  baud_regs_t r_reg;
  baud_regs_t r_next;

  // one tick every div_i+1 clocks, sixteen ticks per bit
  always_comb begin
    r_next = r_reg;
    r_next.tick = (r_reg.cnt >= div_i);
    if (r_reg.cnt >= div_i) begin
      r_next.cnt = 8'h00;
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= BAUD_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_o = r_reg.tick;

endmodule

//--- uart_receive_error_flags.sv
// Function
// - disabling receiver keeps all error flags
// - reset and standby clear error flags
// - clear needs read-as-1 then write 0
// - completion while full sets overrun
// - overrun keeps old data, drops new
// - overrun flag halts reception
// - sync mode overrun inhibits transmission
// - framing and parity checked asynchronous only
// - zero stop bit sets framing flag
// - only first stop bit is checked
// - framing error stores data, full stays
// - framing flag halts reception
// - parity mismatch sets parity error flag
// - parity error stores data, full stays
// - parity flag halts reception
// - clean character sets receive full flag
// - writing 1 leaves flags unchanged
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module uart_receive_error_flags
  import uart_err_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic sclk_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  output logic irq_o,
  output logic receive_full_flag_o,
  output logic tx_inhibit_o
);

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic ck_s1;
    logic ck_s2;
    logic ck_s3;
    rx_state_t st;
    logic [3:0] os;
    logic [2:0] bit_idx;
    logic [7:0] rx_shift_reg;
    logic par_bit;
    logic [7:0] receive_data_holding;
    logic [3:0] flags;
    logic [3:0] armed;
    logic [7:0] serial_mode_reg;
    logic [7:0] divisor;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic tx_inh;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    rx_s1: 1'b1,
    rx_s2: 1'b1,
    ck_s1: 1'b0,
    ck_s2: 1'b0,
    ck_s3: 1'b0,
    st: RX_IDLE,
    os: 4'h0,
    bit_idx: 3'h0,
    rx_shift_reg: 8'h00,
    par_bit: 1'b0,
    receive_data_holding: 8'h00,
    flags: FLAGS_RESET,
    armed: FLAGS_RESET,
    serial_mode_reg: MODE_RESET,
    divisor: DIVISOR_RESET,
    irq_status: IRQ_RESET,
    irq_enable: IRQ_RESET,
    ack: 1'b0,
    dat: 32'h0000_0000,
    irq: 1'b0,
    tx_inh: 1'b0
  };

  regs_t r_reg;
  regs_t r_next;
  logic tick;

  function automatic logic hits(input logic [7:0] adr, input logic [7:0] ofs);
    hits = (adr[7:2] == ofs[7:2]);
  endfunction

  // read view; unmapped and clear register read 0
  function automatic logic [31:0] read_view(input logic [7:0] adr, input regs_t r);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (hits(adr, OFS_STATUS)) begin
      v[STAT_FLAG_MSB:STAT_FLAG_LSB] = r.flags;
    end else if (hits(adr, OFS_DATA)) begin
      v[7:0] = r.receive_data_holding;
    end else if (hits(adr, OFS_MODE)) begin
      v[7:0] = r.serial_mode_reg;
    end else if (hits(adr, OFS_DIVISOR)) begin
      v[7:0] = r.divisor;
    end else if (hits(adr, OFS_IRQ_STATUS)) begin
      v[3:0] = r.irq_status;
    end else if (hits(adr, OFS_IRQ_ENABLE)) begin
      v[3:0] = r.irq_enable;
    end
    read_view = v;
  endfunction

  // standby clears; an event beats a same-cycle clear
  function automatic logic flag_update(input logic cur, input logic clr_bit,
                                       input logic set_bit, input logic stby);
    if (stby) begin
      flag_update = 1'b0;
    end else if (set_bit) begin
      flag_update = 1'b1;
    end else begin
      flag_update = cur & ~clr_bit;
    end
  endfunction

  // ones over data and parity bit against odd or even
  function automatic logic parity_wrong(input logic [7:0] data, input logic pbit,
                                        input logic odd_sel);
    parity_wrong = ((^{data, pbit}) != odd_sel);
  endfunction

  baud_tick_gen u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(r_reg.divisor),
    .tick_o(tick)
  );

  always_comb begin
    logic req;
    logic sync_mode;
    logic rx_en;
    logic parity_en;
    logic odd;
    logic halt;
    logic ck_rise;
    logic rx_done;
    logic stop_ok;
    logic frame_bad;
    logic par_bad;
    logic [7:0] word;
    logic [3:0] clr;
    logic [3:0] ev;
    logic [3:0] raise;
    logic stby;
    req = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    sync_mode = r_reg.serial_mode_reg[MODE_SYNC_BIT];
    rx_en = r_reg.serial_mode_reg[MODE_RX_ENABLE_BIT];
    parity_en = r_reg.serial_mode_reg[MODE_PARITY_EN_BIT];
    odd = r_reg.serial_mode_reg[MODE_ODD_BIT];
    halt = r_reg.flags[FL_OVR] | r_reg.flags[FL_FRM] | r_reg.flags[FL_PAR];
    ck_rise = r_reg.ck_s2 & ~r_reg.ck_s3;
    rx_done = 1'b0;
    stop_ok = 1'b1;
    frame_bad = 1'b0;
    par_bad = 1'b0;
    word = r_reg.rx_shift_reg;
    clr = 4'h0;
    ev = 4'h0;
    raise = 4'h0;
    stby = hw_standby_i | sw_standby_i;
    r_next = r_reg;

    // two-stage synchronisers for the pins
    r_next.rx_s1 = rxd_i;
    r_next.rx_s2 = r_reg.rx_s1;
    r_next.ck_s1 = sclk_i;
    r_next.ck_s2 = r_reg.ck_s1;
    r_next.ck_s3 = r_reg.ck_s2;

    // bus slave: one wait state, ack for one cycle
    r_next.ack = req;
    if (req && !wb_we_i) begin
      r_next.dat = read_view(wb_adr_i, r_reg);
      if (hits(wb_adr_i, OFS_STATUS)) begin
        r_next.armed = r_reg.armed | r_reg.flags;
      end
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      if (hits(wb_adr_i, OFS_STATUS)) begin
        // only a 0 on an armed flag clears it; a 1 is ignored
        clr = r_reg.armed & ~wb_dat_i[STAT_FLAG_MSB:STAT_FLAG_LSB];
        r_next.armed = r_reg.armed & ~clr;
      end else if (hits(wb_adr_i, OFS_MODE)) begin
        // receiver enable changes never touch the flags
        r_next.serial_mode_reg = wb_dat_i[7:0] & MODE_WRITE_MASK;
      end else if (hits(wb_adr_i, OFS_DIVISOR)) begin
        r_next.divisor = wb_dat_i[7:0];
      end else if (hits(wb_adr_i, OFS_IRQ_CLEAR)) begin
        r_next.irq_status = r_reg.irq_status & ~wb_dat_i[3:0];
      end else if (hits(wb_adr_i, OFS_IRQ_ENABLE)) begin
        r_next.irq_enable = wb_dat_i[3:0];
      end
    end

    // receive sequencer
    case (r_reg.st)
      RX_IDLE: begin
        if (rx_en && !halt) begin
          if (sync_mode) begin
            if (ck_rise) begin
              r_next.rx_shift_reg = {r_reg.rx_s2, r_reg.rx_shift_reg[7:1]};
              r_next.bit_idx = 3'h1;
              r_next.st = RX_DATA;
            end
          end else if (!r_reg.rx_s2) begin
            r_next.os = 4'h0;
            r_next.st = RX_START;
          end
        end
      end
      RX_START: begin
        if (tick) begin
          r_next.os = r_reg.os + 4'h1;
          if (r_reg.os == OS_MID) begin
            r_next.os = 4'h0;
            r_next.bit_idx = 3'h0;
            // a high level at mid start bit is a glitch
            r_next.st = r_reg.rx_s2 ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (sync_mode) begin
          if (ck_rise) begin
            word = {r_reg.rx_s2, r_reg.rx_shift_reg[7:1]};
            r_next.rx_shift_reg = word;
            r_next.bit_idx = r_reg.bit_idx + 3'h1;
            if (r_reg.bit_idx == LAST_DATA_BIT) begin
              rx_done = 1'b1;
              r_next.st = RX_IDLE;
            end
          end
        end else if (tick) begin
          r_next.os = r_reg.os + 4'h1;
          if (r_reg.os == OS_LAST) begin
            r_next.rx_shift_reg = {r_reg.rx_s2, r_reg.rx_shift_reg[7:1]};
            r_next.bit_idx = r_reg.bit_idx + 3'h1;
            if (r_reg.bit_idx == LAST_DATA_BIT) begin
              r_next.st = parity_en ? RX_PARITY : RX_STOP;
            end
          end
        end
      end
      RX_PARITY: begin
        if (tick) begin
          r_next.os = r_reg.os + 4'h1;
          if (r_reg.os == OS_LAST) begin
            r_next.par_bit = r_reg.rx_s2;
            r_next.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          r_next.os = r_reg.os + 4'h1;
          if (r_reg.os == OS_LAST) begin
            // second stop bit, if any, is left unsampled
            stop_ok = r_reg.rx_s2;
            rx_done = 1'b1;
            r_next.st = RX_IDLE;
          end
        end
      end
      default: begin
        r_next.st = RX_IDLE;
      end
    endcase

    // dropping the enable aborts the character, flags kept
    if (!rx_en) begin
      r_next.st = RX_IDLE;
    end

    // completion: set beats a same-cycle written clear; standby drops the flag set but not the irq status event
    if (rx_done) begin
      frame_bad = !sync_mode && !stop_ok;
      par_bad = !sync_mode && parity_en && parity_wrong(word, r_reg.par_bit, odd);
      if (r_reg.flags[FL_FULL]) begin
        raise[FL_OVR] = 1'b1;
        ev[IRQ_OVR_BIT] = 1'b1;
      end else begin
        r_next.receive_data_holding = word;
        if (!frame_bad && !par_bad) begin
          raise[FL_FULL] = 1'b1;
          ev[IRQ_FULL_BIT] = 1'b1;
        end
      end
      if (frame_bad) begin
        raise[FL_FRM] = 1'b1;
        ev[IRQ_FRM_BIT] = 1'b1;
      end
      if (par_bad) begin
        raise[FL_PAR] = 1'b1;
        ev[IRQ_PAR_BIT] = 1'b1;
      end
    end
    r_next.irq_status = r_next.irq_status | ev;

    // per flag: standby, then set, then clear
    for (int i = 0; i < 4; i++) begin
      r_next.flags[i] = flag_update(r_reg.flags[i], clr[i], raise[i], stby);
    end

    // standby also idles receiver and drops read marks
    if (stby) begin
      r_next.armed = FLAGS_RESET;
      r_next.st = RX_IDLE;
    end

    // outputs follow the next state
    r_next.irq = |(r_next.irq_status & r_next.irq_enable);
    r_next.tx_inh = r_next.flags[FL_OVR] & r_next.serial_mode_reg[MODE_SYNC_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= REGS_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign irq_o = r_reg.irq;
  assign receive_full_flag_o = r_reg.flags[FL_FULL];
  assign tx_inhibit_o = r_reg.tx_inh;

endmodule

//--- uart_flags_chk.sv
`timescale 1ns/1ps
module uart_flags_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic sclk_i,
  input wire logic hw_standby_i,
  input wire logic sw_standby_i,
  input wire logic irq_o,
  input wire logic receive_full_flag_o,
  input wire logic tx_inhibit_o
);
  logic req;
  logic wr;
  logic stw;
  logic stby;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign stw = wr && wb_adr_i[7:2] == 6'h00;
  assign stby = hw_standby_i || sw_standby_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_dat_hold: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    !irq_o && !receive_full_flag_o && !tx_inhibit_o) else $error("reset left state");
  a_standby_clear: assert property (stby |=> !receive_full_flag_o && !tx_inhibit_o)
    else $error("standby left flags");
  a_write_one: assert property (stw && wb_dat_i[6] && receive_full_flag_o && !stby
    |=> receive_full_flag_o) else $error("write of one cleared flag");
  a_full_cause: assert property ($fell(receive_full_flag_o) |-> $past(stw) || $past(stby))
    else $error("full flag fell alone");
  a_inhibit_cause: assert property ($fell(tx_inhibit_o) |->
    $past(wr) || $past(wr, 2) || $past(stby) || $past(stby, 2)) else $error("inhibit fell alone");
endmodule
bind uart_receive_error_flags uart_flags_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxd_i, .sclk_i,
  .hw_standby_i, .sw_standby_i, .irq_o, .receive_full_flag_o, .tx_inhibit_o);

//--- serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic clk_i,
  output logic rxd_o,
  output logic sclk_o
);
  initial begin
    rxd_o = 1'b1;
    sclk_o = 1'b0;
  end
  task automatic put(input logic b, input int n);
    rxd_o <= b;
    repeat (n) @(posedge clk_i);
  endtask
  // f: parity on, odd, bad parity, bad stop; s2 short low after stop
  task automatic send(input logic [7:0] d, input logic [3:0] f, input int s2);
    int i;
    @(posedge clk_i);
    put(1'b0, 16);
    for (i = 0; i < 8; i++) put(d[i], 16);
    if (f[0]) put(^d ^ f[1] ^ f[2], 16);
    put(!f[3], 16);
    if (s2 > 0) begin
      put(1'b1, 5);
      put(1'b0, s2);
    end
    put(1'b1, 16);
  endtask
  task automatic send_sync(input logic [7:0] d);
    int i;
    @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      rxd_o <= d[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    rxd_o <= ~d[7];
  endtask
endmodule

//--- test_uart_receive_error_flags.sv
`timescale 1ns/1ps
module test_uart_receive_error_flags;
  import uart_err_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic hw = 1'b0;
  logic sw = 1'b0;
  logic [31:0] rdat;
  logic ack, irq, full, inhibit, rxd, sclk;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  uart_receive_error_flags dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rxd_i(rxd), .sclk_i(sclk), .hw_standby_i(hw), .sw_standby_i(sw), .irq_o(irq),
    .receive_full_flag_o(full), .tx_inhibit_o(inhibit));
  serial_tx_model tx (.clk_i, .rxd_o(rxd), .sclk_o(sclk));
  initial forever #5 clk_i = ~clk_i;
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(OFS_DIVISOR, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h0f);
    wr(OFS_MODE, 8'h01);
    rd(8'h1c, 8'h00, "unmapped");
    tx.send(8'ha5, 4'h0, 0);
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h40, "status clean");
    chk("irq", 8'h01, {7'h00, irq});
    chk("full pin", 8'h01, {7'h00, full});
    wr(OFS_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(OFS_IRQ_STATUS, 8'h01, "irq status");
    wr(OFS_IRQ_CLEAR, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00, "irq cleared");
    wr(OFS_STATUS, 8'h40);
    rd(OFS_STATUS, 8'h40, "write one");
    tx.send(8'h3c, 4'h0, 0);
    rd(OFS_STATUS, 8'h60, "overrun");
    rd(OFS_DATA, 8'ha5, "overrun data");
    wr(OFS_STATUS, 8'h20);
    rd(OFS_STATUS, 8'h20, "full cleared");
    tx.send(8'h77, 4'h0, 0);
    rd(OFS_STATUS, 8'h20, "overrun halt");
    rd(OFS_DATA, 8'ha5, "overrun halt data");
    wr(OFS_MODE, 8'h00);
    rd(OFS_STATUS, 8'h20, "rx disabled");
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h00, "overrun cleared");
    wr(OFS_MODE, 8'h01);
    tx.send(8'h81, 4'h8, 0);
    rd(OFS_STATUS, 8'h10, "framing");
    rd(OFS_DATA, 8'h81, "framing data");
    tx.send(8'h22, 4'h0, 0);
    rd(OFS_DATA, 8'h81, "framing halt");
    @(posedge clk_i) sw <= 1'b1;
    @(posedge clk_i) sw <= 1'b0;
    rd(OFS_STATUS, 8'h00, "sw standby");
    wr(OFS_MODE, 8'h05);
    tx.send(8'h96, 4'h1, 0);
    rd(OFS_STATUS, 8'h40, "even parity good");
    wr(OFS_STATUS, 8'h00);
    wr(OFS_MODE, 8'h0d);
    tx.send(8'h13, 4'h7, 0);
    rd(OFS_STATUS, 8'h08, "parity");
    rd(OFS_DATA, 8'h13, "parity data");
    tx.send(8'h55, 4'h3, 0);
    rd(OFS_DATA, 8'h13, "parity halt");
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h00, "parity cleared");
    wr(OFS_MODE, 8'h11);
    tx.send(8'h6e, 4'h0, 6);
    rd(OFS_STATUS, 8'h40, "two stop");
    rd(OFS_DATA, 8'h6e, "two stop data");
    wr(OFS_STATUS, 8'h00);
    wr(OFS_MODE, 8'h03);
    tx.send_sync(8'h11);
    tx.send_sync(8'h22);
    repeat (6) @(posedge clk_i);
    chk("inhibit", 8'h01, {7'h00, inhibit});
    rd(OFS_STATUS, 8'h60, "sync overrun");
    @(posedge clk_i) hw <= 1'b1;
    @(posedge clk_i) hw <= 1'b0;
    rd(OFS_STATUS, 8'h00, "hw standby");
    chk("inhibit off", 8'h00, {7'h00, inhibit});
    complete_run();
  end
endmodule
